// File: rtl/sfd_data_port.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo with valid/ready on both sides

module sfd_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         clr_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o,
    output logic              full_o,
    output logic              empty_o
);
    localparam int PW = $clog2(D);

    logic [W-1:0]  mem_r [D];  // storage words
    logic [PW-1:0] wptr_r;     // next slot to fill
    logic [PW-1:0] rptr_r;     // head slot
    logic [PW:0]   cnt_r;      // occupancy
    logic          push;
    logic          pop;

    // full and empty come straight from the count, never guessed
    assign full_o      = (cnt_r == (PW+1)'(D));
    assign empty_o     = (cnt_r == '0);
    assign in_ready_o  = ~full_o;
    assign out_valid_o = ~empty_o;
    assign out_data_o  = mem_r[rptr_r];
    assign push        = in_valid_i & ~full_o;
    assign pop         = out_ready_i & ~empty_o;

    // storage write, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    // pointers and count; clear empties both ends at once
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && clr_i)) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else if (ce_i) begin
            if (push) begin
                wptr_r <= (wptr_r == PW'(D-1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == PW'(D-1)) ? '0 : rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// data port: receive/transmit queues behind a wishbone slave

module sfd_data_port (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    // register bus
    input  wire sfd_pkg::sfd_wb_req_t wb_i,
    output sfd_pkg::sfd_wb_rsp_t     wb_o,
    // shifter events
    input  wire sfd_pkg::sfd_evt_t   evt_i,
    // receive bytes from the shifter
    input  wire logic                rx_valid_i,
    input  wire logic [7:0]          rx_data_i,
    output logic                     rx_ready_o,
    // transmit bytes to the shifter
    output logic                     tx_valid_o,
    output logic [7:0]               tx_data_o,
    input  wire logic                tx_ready_i,
    // interrupt request
    output logic                     irq_o
);
    import sfd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic          ack_r;       // one-cycle bus answer
    logic [DW-1:0] rdata_r;     // registered read data
    logic          access;      // request taken this edge
    logic          wr;          // write with low lane enabled
    logic          rd;          // read
    logic [DW-1:0] wdat;        // low write byte

    logic          hit_rxd;     // receive data port selected
    logic          hit_txd;     // transmit data port selected
    logic          hit_stat;    // status selected
    logic          hit_intf;    // flags selected
    logic          hit_inte;    // enables selected

    logic          rx_pop;      // head byte consumed by software
    logic          rx_rderr;    // read of empty receive queue
    logic          tx_push;     // byte appended
    logic          tx_wrerr;    // write to full transmit queue
    logic          buf_clr;     // software clears both queues

    logic          rxq_valid;   // receive queue not empty
    logic [DW-1:0] rxq_data;    // receive queue head
    logic          rxq_full;    // receive queue full
    logic          txq_ready;   // transmit queue has room
    logic          txq_empty;   // transmit queue empty

    logic          transmit_write_error_r;      // transmit write error
    logic          receive_read_error_r;      // receive read error
    logic [DW-1:0] inte_r;      // interrupt enables
    logic [DW-1:0] intf_r;      // interrupt flags
    logic [DW-1:0] intf_nxt;    // next value of the flags
    logic [DW-1:0] evt_vec;     // event pulses aligned to flag bits
    logic [DW-1:0] stat_vec;    // status read view

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // a request is taken only once; the ack cycle blocks a second take
    assign access = wb_i.cyc & wb_i.stb & ~ack_r & ce_i;
    assign wr     = access & wb_i.we & wb_i.sel[0];
    assign rd     = access & ~wb_i.we;
    assign wdat   = wb_i.dat[DW-1:0];

    assign hit_rxd  = reg_hit(wb_i.adr, IDX_RXD);
    assign hit_txd  = reg_hit(wb_i.adr, IDX_TXD);
    assign hit_stat = reg_hit(wb_i.adr, IDX_STAT);
    assign hit_intf = reg_hit(wb_i.adr, IDX_INTF);
    assign hit_inte = reg_hit(wb_i.adr, IDX_INTE);

    ////////////////////////////////////////////////////////////////////////////
    // queue side effects of bus access

    // reading the receive port consumes the head byte
    assign rx_pop   = rd & hit_rxd & rxq_valid;

    // reading an empty receive port only raises the error
    assign rx_rderr = rd & hit_rxd & ~rxq_valid;

    // writing the transmit port appends when there is room
    assign tx_push  = wr & hit_txd & txq_ready;

    // a write into a full queue is dropped, data untouched
    assign tx_wrerr = wr & hit_txd & ~txq_ready;

    // clear-buffer bit is a command, it is never stored
    assign buf_clr  = wr & hit_stat & wdat[B_CLB];

    ////////////////////////////////////////////////////////////////////////////
    // queues

    // receive queue: shifter fills, software drains
    sfd_fifo #(
        .W (DW),
        .D (FIFO_DEPTH)
    ) u_rxq (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clr_i       (buf_clr),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_data_i),
        .out_valid_o (rxq_valid),
        .out_ready_i (rx_pop),
        .out_data_o  (rxq_data),
        .full_o      (rxq_full),
        .empty_o     ()
    );

    // transmit queue: software fills, shifter drains;
    // the shifter stalls by holding tx_ready_i low
    sfd_fifo #(
        .W (DW),
        .D (FIFO_DEPTH)
    ) u_txq (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clr_i       (buf_clr),
        .in_valid_i  (tx_push),
        .in_ready_o  (txq_ready),
        .in_data_i   (wdat),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o),
        .full_o      (),
        .empty_o     (txq_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus answer

    // ack one cycle after the take, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else if (ce_i) begin
            ack_r <= access;
        end
    end

    // status view: reserved bits and the clear command read zero
    always_comb begin
        stat_vec         = '0;
        stat_vec[B_TRANSMIT_WRITE_ERROR] = transmit_write_error_r;
        stat_vec[B_TXBE] = txq_empty;
        stat_vec[B_RECEIVE_READ_ERROR] = receive_read_error_r;
        stat_vec[B_RXBF] = rxq_full;
    end

    // read data captured with the take; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (ce_i && access) begin
            if (wb_i.we) begin
                // transmit port and writes answer zero
                rdata_r <= '0;
            end else if (hit_rxd) begin
                // head byte, or zero when the queue is empty
                rdata_r <= rxq_valid ? rxq_data : RXD_EMPTY;
            end else if (hit_stat) begin
                rdata_r <= stat_vec;
            end else if (hit_intf) begin
                rdata_r <= intf_r;
            end else if (hit_inte) begin
                rdata_r <= inte_r;
            end else begin
                rdata_r <= '0;
            end
        end
    end

    assign wb_o = '{ack: ack_r, dat: {{(BUS_W-DW){1'b0}}, rdata_r}};

    ////////////////////////////////////////////////////////////////////////////
    // error flags

    // set wins over a clear in the same cycle so no error is lost;
    // software clears by writing zero to the bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transmit_write_error_r <= 1'b0;
        end else if (ce_i) begin
            if (tx_wrerr) begin
                transmit_write_error_r <= 1'b1;
            end else if (wr && hit_stat && !wdat[B_TRANSMIT_WRITE_ERROR]) begin
                transmit_write_error_r <= 1'b0;
            end
        end
    end

    // receive read error, same set-wins scheme
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_read_error_r <= 1'b0;
        end else if (ce_i) begin
            if (rx_rderr) begin
                receive_read_error_r <= 1'b1;
            end else if (wr && hit_stat && !wdat[B_RECEIVE_READ_ERROR]) begin
                receive_read_error_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt enables and flags

    // unimplemented enable bits stay zero whatever is written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inte_r <= INTE_RST;
        end else if (ce_i && wr && hit_inte) begin
            inte_r <= wdat & IRQ_MASK;
        end
    end

    // event pulses lined up with their flag bits
    always_comb begin
        evt_vec         = '0;
        // shifter-empty only counts while acting as master
        evt_vec[B_SRMT] = evt_i.transfer_done & evt_i.master_mode;
        evt_vec[B_TCZ]  = evt_i.count_zero;
        evt_vec[B_SOS]  = evt_i.sel_start;
        evt_vec[B_EOS]  = evt_i.sel_end;
        evt_vec[B_RXO]  = evt_i.rx_overflow;
        evt_vec[B_TXU]  = evt_i.tx_underflow;
    end

    // each flag is software-writable, hardware set wins;
    // next values per bit keep the flag word to a single storing process
    for (genvar i = 0; i < DW; i++) begin : g_flag
        if (IRQ_MASK[i]) begin : g_impl
            assign intf_nxt[i] = evt_vec[i] ? 1'b1
                               : (wr && hit_intf) ? wdat[i] : intf_r[i];
        end else begin : g_none
            // reserved flag position reads zero
            assign intf_nxt[i] = 1'b0;
        end
    end

    // flag storage, frozen while the clock enable is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intf_r <= INTF_RST;
        end else if (ce_i) begin
            intf_r <= intf_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt request

    // combinational so it drops the same cycle a flag is cleared;
    // bit 7 of the enables gates the shifter-empty flag
    assign irq_o = |(intf_r & inte_r);

endmodule
`default_nettype wire

// File: rtl/sfd_pkg.sv
// Operation
// - read of nonempty receive queue pops head byte
// - read of empty queue returns zero, flags error
// - write to nonfull transmit queue appends byte
// - write to full queue dropped, flags error
// - receive port reads head; transmit port write-only
// - enable bit 7 gates shifter-empty event
// - enable bits 7,6,5,4,2,1; reset zero
// - error flags status bits 3, 7; software clears
// - shifter-empty set on master transfer done only
`default_nettype none
package sfd_pkg;
    localparam int DW         = 8;   // data port width
    localparam int FIFO_DEPTH = 8;   // words per queue
    localparam int AW         = 12;  // byte address width
    localparam int BUS_W      = 32;  // wishbone data width
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_RXD  = 10'h080;
    localparam logic [9:0] IDX_TXD  = 10'h081;
    localparam logic [9:0] IDX_STAT = 10'h087;
    localparam logic [9:0] IDX_INTF = 10'h08a;
    localparam logic [9:0] IDX_INTE = 10'h08b;
    // status bit positions
    localparam int B_TRANSMIT_WRITE_ERROR = 7;
    localparam int B_TXBE = 5;
    localparam int B_RECEIVE_READ_ERROR = 3;
    localparam int B_CLB  = 2;
    localparam int B_RXBF = 0;
    // interrupt flag and enable bit positions
    localparam int B_SRMT = 7;
    localparam int B_TCZ  = 6;
    localparam int B_SOS  = 5;
    localparam int B_EOS  = 4;
    localparam int B_RXO  = 2;
    localparam int B_TXU  = 1;
    localparam logic [DW-1:0] IRQ_MASK  = 8'hf6;  // implemented bits
    localparam logic [DW-1:0] INTE_RST  = 8'h00;
    localparam logic [DW-1:0] INTF_RST  = 8'h00;
    localparam logic [DW-1:0] RXD_EMPTY = 8'h00;
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [3:0]       sel;
        logic [AW-1:0]    adr;
        logic [BUS_W-1:0] dat;
    } sfd_wb_req_t;
    typedef struct packed {
        logic             ack;
        logic [BUS_W-1:0] dat;
    } sfd_wb_rsp_t;
    // one-cycle event pulses and mode level from the shifter
    typedef struct packed {
        logic transfer_done;
        logic master_mode;
        logic count_zero;
        logic sel_start;
        logic sel_end;
        logic rx_overflow;
        logic tx_underflow;
    } sfd_evt_t;
    // word index match of a byte address
    function automatic logic reg_hit(input logic [AW-1:0] adr, input logic [9:0] idx);
        return adr[AW-1:2] == idx;
    endfunction
endpackage
`default_nettype wire

// File: test/sfd_data_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfd_data_port_monitor
    import sfd_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 ce_i,
    input wire sfd_pkg::sfd_wb_req_t wb_i,
    input wire sfd_pkg::sfd_wb_rsp_t wb_o,
    input wire sfd_pkg::sfd_evt_t    evt_i,
    input wire logic                 rx_valid_i,
    input wire logic [7:0]           rx_data_i,
    input wire logic                 rx_ready_o,
    input wire logic                 tx_valid_o,
    input wire logic [7:0]           tx_data_o,
    input wire logic                 tx_ready_i,
    input wire logic                 irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       tk;     // bus request taken this edge
    logic [9:0] idx;    // word index of the request
    logic [7:0] ena_r;  // shadow of the enable register, so irq can be judged
    assign tk  = wb_i.cyc && wb_i.stb && !wb_o.ack && ce_i;
    assign idx = wb_i.adr[11:2];
    ////////////////////////////////////////////////////////////////////////////
    // enable shadow follows software writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ena_r <= 8'h00;
        end else if (tk && wb_i.we && wb_i.sel[0] && idx == IDX_INTE) begin
            ena_r <= wb_i.dat[7:0] & IRQ_MASK;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_ack_take; tk |=> wb_o.ack; endproperty
    a_ack_take: assert property (p_ack_take) else $error("request not acked");
    property p_ack_once; wb_o.ack |=> !wb_o.ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_rd_hi; wb_o.ack |-> (wb_o.dat[31:8] == 24'h000000); endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_txrd_zero; (tk && !wb_i.we && idx == IDX_TXD) |=> (wb_o.dat == 32'h0); endproperty
    a_txrd_zero: assert property (p_txrd_zero) else $error("transmit port readable");
    property p_tx_push;
        (tk && wb_i.we && wb_i.sel[0] && idx == IDX_TXD && !tx_valid_o)
            |=> (tx_valid_o && tx_data_o == $past(wb_i.dat[7:0]));
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("byte not queued");
    property p_tx_hold; (tx_valid_o && !tx_ready_i && !tk && ce_i) |=> (tx_valid_o && $stable(tx_data_o)); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit head changed");
    property p_rx_pop; (tk && !wb_i.we && idx == IDX_RXD && !rx_ready_o) |=> rx_ready_o; endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("read did not free a slot");
    property p_irq_srmt;
        (evt_i.transfer_done && evt_i.master_mode && ce_i && ena_r[B_SRMT] && !(tk && wb_i.we)) |=> irq_o;
    endproperty
    a_irq_srmt: assert property (p_irq_srmt) else $error("shifter empty irq missing");
    property p_irq_none; (ena_r == 8'h00) |-> !irq_o; endproperty
    a_irq_none: assert property (p_irq_none) else $error("irq with nothing enabled");
    c_rx_full: cover property (tk && !wb_i.we && idx == IDX_RXD && !rx_ready_o);
    c_tx_push: cover property (tk && wb_i.we && idx == IDX_TXD);
    c_irq: cover property ($rose(irq_o));
endmodule
bind sfd_data_port sfd_data_port_monitor sfd_data_port_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_i(wb_i), .wb_o(wb_o), .evt_i(evt_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .irq_o(irq_o));
`default_nettype wire

// File: test/sfd_data_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sfd_data_port_tb;
    import sfd_pkg::*;
    logic        clk_i, rst_i, ce;
    sfd_wb_req_t req;
    sfd_wb_rsp_t rsp;
    sfd_evt_t    evt;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, irq;
    logic [7:0]  rx_data, tx_data;
    logic [31:0] exp_q[$];        // awaited bus answers
    logic [7:0]  rxm[$], txm[$];  // queue models
    logic [31:0] r;               // lfsr state
    int          n_fail, checks, i, n;
    logic [7:0]  fb[5] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02};  // flag bit per event
    logic [6:0]  ev[5] = '{7'h10, 7'h08, 7'h04, 7'h02, 7'h01};  // event pulse per flag
    sfd_data_port sfd_data_port_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(req), .wb_o(rsp), .evt_i(evt),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .tx_ready_i(tx_ready), .irq_o(irq));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled, then one idle cycle
    // no cycle count is assumed: only the watchdog ends a wait for ack
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [31:0] e);
        exp_q.push_back(e);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: {idx, 2'b00}, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
        end while (rsp.ack !== 1'b1);
        req <= '0;
        @(posedge clk_i);
    endtask
    // pulse one event, look at irq, read then clear the flags
    task automatic pulse(input logic [6:0] v, input logic ei, input logic [7:0] ef);
        evt <= v;
        @(posedge clk_i);
        evt <= '0;
        @(posedge clk_i);
        chk("irq", {31'h0, irq}, {31'h0, ei});
        bus(1'b0, IDX_INTF, 8'h00, {24'h0, ef});
        bus(1'b1, IDX_INTF, 8'h00, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // result watchers take the oldest note whenever an answer shows
    always @(posedge clk_i) begin
        if (rsp.ack === 1'b1) chk("wb_dat", rsp.dat, exp_q.pop_front());
    end
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid === 1'b1 && tx_ready === 1'b1) chk("tx_data", {24'h0, tx_data}, {24'h0, txm.pop_front()});
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        ce = 1'b1;
        req = '0;
        evt = '0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
        r = 32'd94142;
        n_fail = 0;
        checks = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, access kinds, unmapped place
        bus(1'b0, IDX_INTE, 8'h00, 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h20);
        bus(1'b1, IDX_INTE, 8'hff, 32'h0);
        bus(1'b0, IDX_INTE, 8'h00, 32'hf6);
        bus(1'b1, 10'h0ff, 8'h5a, 32'h0);
        bus(1'b0, 10'h0ff, 8'h00, 32'h0);
        bus(1'b0, IDX_TXD, 8'h00, 32'h0);
        $display("test registers done");
        // fill the receive queue until it refuses, then drain past empty
        rx_valid <= 1'b1;
        r = lfsr(r);
        rx_data <= r[7:0];
        n = 0;
        while (rxm.size() < 8 && n < 40) begin
            @(posedge clk_i);
            n++;
            if (rx_ready === 1'b1) begin
                rxm.push_back(rx_data);
                r = lfsr(r);
                rx_data <= r[7:0];
            end
        end
        @(posedge clk_i);
        rx_valid <= 1'b0;
        chk("rx_ready", {31'h0, rx_ready}, 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h21);
        for (i = 0; i < 9; i++) bus(1'b0, IDX_RXD, 8'h00, rxm.size() > 0 ? {24'h0, rxm.pop_front()} : 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h28);
        bus(1'b1, IDX_STAT, 8'h00, 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h20);
        $display("test receive done");
        // fill the transmit queue past full with the shifter stalled
        for (i = 0; i < 9; i++) begin
            r = lfsr(r);
            if (i < 8) txm.push_back(r[7:0]);
            bus(1'b1, IDX_TXD, r[7:0], 32'h0);
        end
        bus(1'b0, IDX_STAT, 8'h00, 32'h80);
        tx_ready <= 1'b1;
        n = 0;
        while (tx_valid === 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        tx_ready <= 1'b0;
        chk("tx_left", txm.size(), 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'ha0);
        bus(1'b1, IDX_STAT, 8'h00, 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h20);
        // clear-buffer command empties a queue holding one byte
        bus(1'b1, IDX_TXD, 8'h3c, 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h00);
        bus(1'b1, IDX_STAT, 8'h04, 32'h0);
        bus(1'b0, IDX_STAT, 8'h00, 32'h20);
        $display("test transmit done");
        // shifter empty in master, in slave, masked; then every other event
        bus(1'b1, IDX_INTE, 8'h80, 32'h0);
        pulse(7'h60, 1'b1, 8'h80);
        pulse(7'h40, 1'b0, 8'h00);
        bus(1'b1, IDX_INTE, 8'h00, 32'h0);
        pulse(7'h60, 1'b0, 8'h80);
        for (i = 0; i < 5; i++) begin
            bus(1'b1, IDX_INTE, fb[i], 32'h0);
            pulse(ev[i], 1'b1, fb[i]);
        end
        // an enabled event while the clock enable is low must be lost
        ce <= 1'b0;
        evt <= 7'h01;
        @(posedge clk_i);
        evt <= '0;
        @(posedge clk_i);
        ce <= 1'b1;
        @(posedge clk_i);
        chk("irq_frozen", {31'h0, irq}, 32'h0);
        bus(1'b0, IDX_INTF, 8'h00, 32'h0);
        $display("test interrupts done");
        print_verdict();
    end
endmodule
`default_nettype wire
